// ### core/pin_mux_defines.vh
// Purpose: constants for the shared pin mux and port I/O block
// Assumes: 16-bit data space, word registers at byte-style addresses
// Notes:   addresses are data-space byte addresses, two apart per word
`ifndef PIN_MUX_DEFINES_VH
`define PIN_MUX_DEFINES_VH
`define ADDR_MUX_SEL_A    16'h7090
`define ADDR_MUX_SEL_B    16'h7092
`define ADDR_PORT_A       16'h7098
`define ADDR_PORT_B       16'h709A
`define ADDR_PORT_C       16'h709C
`define RESET_WORD        16'h0000
`define MUX_A_MASK        16'hFF0F
`define MUX_B_MASK        16'h00FD
`define PORT_A_MASK       16'h0F0F
`define PORT_FULL_MASK    16'hFFFF
`define DIR_LSB           8
`define CLKSEL_IO         2'h0
`define CLKSEL_SRC1       2'h1
`define CLKSEL_SRC2       2'h2
`define CLKSEL_SRC3       2'h3
`define CLK_PIN_INDEX     1
`define INV_POL_B_MASK    8'h0C
`endif

// ### core/shared_pin_io_mux.v
// Purpose: pin multiplexing and port I/O for the 20 group-one shared pins
// Assumes: single clk, CPU data-space word access, pins given as in/out/oe
// Notes:   group-two pins stay with their own peripherals; no logic here
`timescale 1ns/10ps
`include "pin_mux_defines.vh"
`default_nettype none
module shared_pin_io_mux (
  input  wire        clk,           // system clock
  input  wire        rst_n,         // async reset, low
  input  wire [15:0] addr,          // data-space address
  input  wire [15:0] wdata,         // write data
  input  wire        wr,            // write strobe
  input  wire        rd,            // read strobe
  output reg  [15:0] rdata,         // read data
  output wire        hit,           // address decodes here
  input  wire [1:0]  clkSel,        // system control bits 7:6
  input  wire [2:0]  clkSources,    // clock sources for codes 1..3
  input  wire [3:0]  portAPinIn,    // port A pin levels
  output wire [3:0]  portAPinOut,   // port A pin drive
  output wire [3:0]  portAPinOe,    // port A pin enable
  input  wire [7:0]  portBPinIn,    // port B pin levels
  output wire [7:0]  portBPinOut,   // port B pin drive
  output wire [7:0]  portBPinOe,    // port B pin enable
  input  wire [7:0]  portCPinIn,    // port C pin levels
  output wire [7:0]  portCPinOut,   // port C pin drive
  output wire [7:0]  portCPinOe,    // port C pin enable
  input  wire [7:0]  periphBOut,    // primary outputs for port B pins
  input  wire [7:0]  periphBOe,     // primary enables for port B pins
  input  wire [7:0]  periphCOut,    // primary outputs for port C pins
  input  wire [7:0]  periphCOe,     // primary enables for port C pins
  output wire [3:0]  periphAIn,     // analog-input pins to converter side
  output wire [7:0]  periphBIn,     // port B pins to primary functions
  output wire [7:0]  periphCIn,     // port C pins to primary functions
  output wire [3:0]  primSelA,      // primary selected, port A pins
  output wire [7:0]  primSelB,      // primary selected, port B pins
  output wire [7:0]  primSelC       // primary selected, port C pins
);

  // control registers
  reg  [15:0] pin_mux_select_a;
  reg  [15:0] pin_mux_select_b;
  reg  [15:0] port_a_data_direction;
  reg  [15:0] port_b_data_direction;
  reg  [15:0] port_c_data_direction;

  // two-flop pin synchronisers
  reg  [3:0]  syncA1;
  reg  [3:0]  syncA2;
  reg  [7:0]  syncB1;
  reg  [7:0]  syncB2;
  reg  [7:0]  syncC1;
  reg  [7:0]  syncC2;

  // register decode and read path
  reg  [15:0] next_rdata;
  wire        selMuxA;
  wire        selMuxB;
  wire        selPortA;
  wire        selPortB;
  wire        selPortC;

  // pin steering
  wire [7:0]  ioSelC;
  wire        clkPinIo;
  reg         clkOutLevel;
  reg  [3:0]  driveA;
  reg  [3:0]  enableA;
  reg  [7:0]  driveB;
  reg  [7:0]  enableB;
  reg  [7:0]  driveC;
  reg  [7:0]  enableC;

  // pins pass two flops before the read path sees them
  // first flop may go metastable, so only the second is read
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA1 <= 4'h0;
      syncA2 <= 4'h0;
    end else begin
      syncA1 <= portAPinIn;
      syncA2 <= syncA1;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncB1 <= 8'h00;
      syncB2 <= 8'h00;
    end else begin
      syncB1 <= portBPinIn;
      syncB2 <= syncB1;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncC1 <= 8'h00;
      syncC2 <= 8'h00;
    end else begin
      syncC1 <= portCPinIn;
      syncC2 <= syncC1;
    end
  end

  // one compare per register, used only by the hit decode
  function addrMatch;
    input [15:0] a;
    input [15:0] target;
    begin
      addrMatch = (a == target);
    end
  endfunction

  assign selMuxA  = addrMatch(addr, `ADDR_MUX_SEL_A);
  assign selMuxB  = addrMatch(addr, `ADDR_MUX_SEL_B);
  assign selPortA = addrMatch(addr, `ADDR_PORT_A);
  assign selPortB = addrMatch(addr, `ADDR_PORT_B);
  assign selPortC = addrMatch(addr, `ADDR_PORT_C);

  assign hit = selMuxA | selMuxB | selPortA | selPortB | selPortC;

  // word writes; all clear on reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_mux_select_a      <= `RESET_WORD;
      pin_mux_select_b      <= `RESET_WORD;
      port_a_data_direction <= `RESET_WORD;
      port_b_data_direction <= `RESET_WORD;
      port_c_data_direction <= `RESET_WORD;
    end else if (wr) begin
      case (addr)
        `ADDR_MUX_SEL_A: begin
          pin_mux_select_a <= wdata & `MUX_A_MASK;
        end
        // no select bit for the clock pin
        `ADDR_MUX_SEL_B: begin
          pin_mux_select_b <= wdata & `MUX_B_MASK;
        end
        `ADDR_PORT_A: begin
          port_a_data_direction <= wdata & `PORT_A_MASK;
        end
        `ADDR_PORT_B: begin
          port_b_data_direction <= wdata & `PORT_FULL_MASK;
        end
        `ADDR_PORT_C: begin
          port_c_data_direction <= wdata & `PORT_FULL_MASK;
        end
        default: begin
        end
      endcase
    end
  end

  // bits 2,3 of select B are inverted
  function [7:0] ioFromSelB;
    input [7:0] sel;
    begin
      ioFromSelB = (~sel & ~`INV_POL_B_MASK) | (sel & `INV_POL_B_MASK);
    end
  endfunction

  assign ioSelC = ioFromSelB(pin_mux_select_b[7:0]);
  // code zero keeps the clock pin as port C bit 1
  assign clkPinIo = (clkSel == `CLKSEL_IO);

  // codes 1..3 pick one of three clock sources
  always @* begin
    case (clkSel)
      `CLKSEL_SRC1: begin
        clkOutLevel = clkSources[0];
      end
      `CLKSEL_SRC2: begin
        clkOutLevel = clkSources[1];
      end
      `CLKSEL_SRC3: begin
        clkOutLevel = clkSources[2];
      end
      default: begin
        clkOutLevel = 1'b0;
      end
    endcase
  end

  assign primSelA      = pin_mux_select_a[3:0];
  assign primSelB      = pin_mux_select_a[15:8];
  assign primSelC[7:2] = ~ioSelC[7:2];
  assign primSelC[1]   = ~clkPinIo;
  assign primSelC[0]   = ~ioSelC[0];

  // read of data bits: sampled pin when input, latch when output
  function [7:0] dataView;
    input [15:0] r;
    input [7:0]  pins;
    begin
      dataView = (r[7:0] & r[15:`DIR_LSB]) | (pins & ~r[15:`DIR_LSB]);
    end
  endfunction

  // data low byte, direction high byte
  always @* begin
    next_rdata = `RESET_WORD;
    case (addr)
      `ADDR_MUX_SEL_A: begin
        next_rdata = pin_mux_select_a;
      end
      `ADDR_MUX_SEL_B: begin
        next_rdata = pin_mux_select_b;
      end
      `ADDR_PORT_A: begin
        next_rdata = {port_a_data_direction[15:8],
                      dataView(port_a_data_direction, {4'h0, syncA2})} & `PORT_A_MASK;
      end
      `ADDR_PORT_B: begin
        next_rdata = {port_b_data_direction[15:8],
                      dataView(port_b_data_direction, syncB2)};
      end
      `ADDR_PORT_C: begin
        next_rdata = {port_c_data_direction[15:8],
                      dataView(port_c_data_direction, syncC2)};
      end
      // unmapped words read as zero
      default: begin
        next_rdata = `RESET_WORD;
      end
    endcase
  end

  // read data holds between reads, so the master may take it late
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= `RESET_WORD;
    end else if (rd) begin
      rdata <= next_rdata;
    end
  end

  // pick primary or port value per pin
  function [7:0] steer;
    input [7:0] prim;
    input [7:0] primVal;
    input [7:0] portVal;
    begin
      steer = (prim & primVal) | (~prim & portVal);
    end
  endfunction

  // port A primary is an analog input, never driven
  always @* begin
    driveA  = port_a_data_direction[3:0];
    enableA = ~primSelA & port_a_data_direction[11:8];
  end

  always @* begin
    driveB  = steer(primSelB, periphBOut, port_b_data_direction[7:0]);
    enableB = steer(primSelB, periphBOe, port_b_data_direction[15:8]);
  end

  // clock pin overrides port C bit 1 when code nonzero
  // the peripheral drive of bit 1 is ignored: that pin's primary is the clock output
  always @* begin
    driveC  = steer(primSelC, periphCOut, port_c_data_direction[7:0]);
    enableC = steer(primSelC, periphCOe, port_c_data_direction[15:8]);
    if (!clkPinIo) begin
      driveC[`CLK_PIN_INDEX]  = clkOutLevel;
      enableC[`CLK_PIN_INDEX] = 1'b1;
    end
  end

  // drive in I/O mode with direction 1, else per peripheral enable (B, C) or clock code (C bit 1)
  assign portAPinOut = driveA;
  assign portAPinOe  = enableA;
  assign portBPinOut = driveB;
  assign portBPinOe  = enableB;
  assign portCPinOut = driveC;
  assign portCPinOe  = enableC;

  // primary-function inputs see synchronised pin levels
  assign periphAIn = syncA2;
  assign periphBIn = syncB2;
  assign periphCIn = syncC2;

endmodule
`default_nettype wire

// ### sim/pin_mux_props.sv
// Purpose: concurrent checks on the shared pin mux ports
// Assumes: one clock, async active-low reset
// Notes:   bound to the block from the bench top
`timescale 1ns/10ps
`default_nettype none
module pin_mux_props (
  input wire logic        clk,         // clock
  input wire logic        rst_n,       // reset, low
  input wire logic [15:0] addr,        // address
  input wire logic [15:0] wdata,       // write data
  input wire logic        wr,          // write strobe
  input wire logic        rd,          // read strobe
  input wire logic [15:0] rdata,       // read data
  input wire logic        hit,         // decode
  input wire logic [1:0]  clkSel,      // clock pin code
  input wire logic [2:0]  clkSources,  // clock sources
  input wire logic [3:0]  portAPinOe,  // port A enable
  input wire logic [7:0]  portBPinOut, // port B drive
  input wire logic [7:0]  portBPinOe,  // port B enable
  input wire logic [7:0]  portCPinOut, // port C drive
  input wire logic [7:0]  portCPinOe,  // port C enable
  input wire logic [7:0]  periphBOut,  // primary drive B
  input wire logic [7:0]  periphBOe,   // primary enable B
  input wire logic [3:0]  primSelA,    // primary flags A
  input wire logic [7:0]  primSelB,    // primary flags B
  input wire logic [7:0]  primSelC     // primary flags C
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_reset_io_mode: assert property ($rose(rst_n) |->
    primSelA == 4'h0 && primSelB == 8'h00 && primSelC[3:2] == 2'h3) else $error("mux not cleared by reset");
  a_mux_a_write: assert property (wr && addr == 16'h7090 |=>
    primSelB == $past(wdata[15:8]) && primSelA == $past(wdata[3:0])) else $error("select A not applied");
  a_mux_b_inverted: assert property (wr && addr == 16'h7092 |=>
    primSelC[7:2] == ($past(wdata[7:2]) ^ 6'h03) && primSelC[0] == $past(wdata[0])) else $error("select B wrong");
  a_prim_b_drive: assert property (((portBPinOe ^ periphBOe) & primSelB) == 8'h00 &&
    ((portBPinOut ^ periphBOut) & primSelB & periphBOe) == 8'h00) else $error("primary drive wrong");
  a_port_a_nodrive: assert property ((portAPinOe & primSelA) == 4'h0)
    else $error("analog pin driven");
  a_dir_b_write: assert property (wr && addr == 16'h709A |=>
    ((portBPinOe ^ $past(wdata[15:8])) & ~primSelB) == 8'h00) else $error("direction not applied");
  a_clk_pin_src: assert property (clkSel != 2'h0 |->
    portCPinOe[1] && portCPinOut[1] == clkSources[clkSel - 2'h1]) else $error("clock pin source wrong");
  a_unmapped_zero: assert property (rd && !hit |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// Purpose: self-checking bench for the shared pin mux block
// Assumes: read data one cycle after rd, pin inputs pass two flops
// Notes:   random words from an xorshift seeded at 46
`timescale 1ns/10ps
`include "pin_mux_defines.vh"
`default_nettype none
module tb_top;
  logic        clk, rst_n, wr, rd, hit;
  logic [15:0] addr, wdata, rdata, v, w, a;
  logic [1:0]  clkSel;
  logic [2:0]  clkSources;
  logic [3:0]  portAPinIn, portAPinOut, portAPinOe, periphAIn, primSelA;
  logic [7:0]  portBPinIn, portBPinOut, portBPinOe, portCPinIn, portCPinOut, portCPinOe, primSelB, primSelC;
  logic [7:0]  periphBOut, periphBOe, periphCOut, periphCOe, periphBIn, periphCIn;
  logic [31:0] seed = 32'h0000002E;
  int          n_mismatch = 0, checked = 0, cyc = 0;
  shared_pin_io_mux i_shared_pin_io_mux (
    .clk         (clk),
    .rst_n       (rst_n),
    .addr        (addr),
    .wdata       (wdata),
    .wr          (wr),
    .rd          (rd),
    .rdata       (rdata),
    .hit         (hit),
    .clkSel      (clkSel),
    .clkSources  (clkSources),
    .portAPinIn  (portAPinIn),
    .portAPinOut (portAPinOut),
    .portAPinOe  (portAPinOe),
    .portBPinIn  (portBPinIn),
    .portBPinOut (portBPinOut),
    .portBPinOe  (portBPinOe),
    .portCPinIn  (portCPinIn),
    .portCPinOut (portCPinOut),
    .portCPinOe  (portCPinOe),
    .periphBOut  (periphBOut),
    .periphBOe   (periphBOe),
    .periphCOut  (periphCOut),
    .periphCOe   (periphCOe),
    .periphAIn   (periphAIn),
    .periphBIn   (periphBIn),
    .periphCIn   (periphCIn),
    .primSelA    (primSelA),
    .primSelB    (primSelB),
    .primSelC    (primSelC)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // data bits with direction 0 read back the pin
  function automatic logic [15:0] expect_rd(input logic [15:0] ad, input logic [15:0] d);
    logic [15:0] m, r, p;
    m = (ad == `ADDR_PORT_A) ? `PORT_A_MASK : `PORT_FULL_MASK;
    p = (ad == `ADDR_PORT_A) ? {12'h000, portAPinIn} : (ad == `ADDR_PORT_B) ? {8'h00, portBPinIn} : {8'h00, portCPinIn};
    r = d & m;
    if (ad == `ADDR_MUX_SEL_A) return d & `MUX_A_MASK;
    if (ad == `ADDR_MUX_SEL_B) return d & `MUX_B_MASK;
    if (ad != `ADDR_PORT_A && ad != `ADDR_PORT_B && ad != `ADDR_PORT_C) return `RESET_WORD;
    return {r[15:8], (r[7:0] & r[15:8]) | (p[7:0] & ~r[15:8] & m[7:0])};
  endfunction
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr16(input logic [15:0] ad, input logic [15:0] d);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd16(input logic [15:0] ad, output logic [15:0] d);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
  task automatic test_done();
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    {wr, rd, addr, wdata, clkSel, clkSources, portAPinIn, portBPinIn, portCPinIn} = '0;
    {periphBOut, periphBOe, periphCOut, periphCOe} = '0;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      a = 16'h7090 + 16'(2 * i);
      rd16(a, v);
      cmp(v, expect_rd(a, `RESET_WORD));
      cmp(16'(hit), 16'(a != 16'h7094 && a != 16'h7096));
    end
    wr16(`ADDR_MUX_SEL_B, 16'h000C);
    for (int i = 0; i < 60; i++) begin
      w = rnd();
      a = (i < 45) ? 16'h7098 + 16'(2 * (rnd() % 3)) : 16'h7090 + 16'(2 * (rnd() % 2));
      {portAPinIn, portBPinIn, portCPinIn} <= 20'(rnd());
      {periphBOut, periphBOe, periphCOut, periphCOe, clkSources} <= 35'(rnd() * 7);
      wr16(a, w);
      rd16(a, v);
      cmp(v, expect_rd(a, w));
      cmp(16'(hit), 16'h0001);
      cmp({periphBIn, periphCIn}, {portBPinIn, portCPinIn});
      cmp({12'h000, periphAIn}, {12'h000, portAPinIn});
      if (a == `ADDR_PORT_A) cmp({8'h00, portAPinOe, portAPinOut & portAPinOe}, {8'h00, w[11:8], w[3:0] & w[11:8]});
      if (a == `ADDR_PORT_B) cmp({portBPinOe, portBPinOut & portBPinOe}, {w[15:8], w[7:0] & w[15:8]});
      if (a == `ADDR_PORT_C) cmp({portCPinOe, portCPinOut & portCPinOe}, {w[15:8], w[7:0] & w[15:8]});
    end
    for (int k = 1; k < 4; k++) begin
      clkSel <= 2'(k);
      @(posedge clk);
      @(negedge clk);
      cmp({14'h0, portCPinOe[1], portCPinOut[1]}, {14'h0, 1'b1, clkSources[k - 1]});
      @(posedge clk);
    end
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    clkSel <= 2'h0;
    @(posedge clk);
    rd16(`ADDR_MUX_SEL_A, v);
    cmp(v, `RESET_WORD);
    rd16(`ADDR_PORT_B, v);
    cmp(v, expect_rd(`ADDR_PORT_B, `RESET_WORD));
    cmp({4'h0, portAPinOe, portBPinOe}, 16'h0000);
    cmp({portCPinOe, primSelC}, {4'h0, periphCOe[3:2], 2'h0, 8'h0C});
    test_done();
  end
endmodule
bind shared_pin_io_mux pin_mux_props i_pin_mux_props (
  .clk         (clk),
  .rst_n       (rst_n),
  .addr        (addr),
  .wdata       (wdata),
  .wr          (wr),
  .rd          (rd),
  .rdata       (rdata),
  .hit         (hit),
  .clkSel      (clkSel),
  .clkSources  (clkSources),
  .portAPinOe  (portAPinOe),
  .portBPinOut (portBPinOut),
  .portBPinOe  (portBPinOe),
  .portCPinOut (portCPinOut),
  .portCPinOe  (portCPinOe),
  .periphBOut  (periphBOut),
  .periphBOe   (periphBOe),
  .primSelA    (primSelA),
  .primSelB    (primSelB),
  .primSelC    (primSelC)
);
`default_nettype wire
